// >>> rtl/pin_route_pkg.sv
// Package with register map, codes and carrier types of the pin routing matrix
// Functional notes
// [R1] Every pin owns its output source selector
// [R2] Output code zero drives the port latch
// [R3] Direction bit normally controls the output driver
// [R4] Serial, I2C and generator may override direction
// [R5] Override applies for serial, I2C, generator codes
// [R6] Software routes bidirectional input and output alike
// [R7] Lock bit freezes every selector write
// [R8] Lock change needs 0x55 then 0xAA first
// [R9] One-way mode: one clear, one set
// [R10] One-way lock stays set until reset
// [R11] Sleep leaves all selections untouched
// [R12] Power-on reset restores selector defaults
// [R13] Other resets keep selections unchanged
// [R14] Input selector is bits 4..0, rest zero
// [R15] Small variant: port A 0-5, port C 0-5
// [R16] Large variant adds port B 4-7, C 6-7
// [R17] Logic cell, generator, compare, pulse codes
// [R18] Serial, comparator codes; reserved codes listed
// [R19] Output selector clears at power-on, rest zero
// [R20] Many inputs may share one source pin
// [R21] Port read always returns real pin level
// [R22] Lock flag is bit 0, others zero
// [R23] Unkeyed lock write ignored, broken keys restart
// [R24] Software masks interrupts around key sequence
package pin_route_pkg;

  // Bus and field geometry
  localparam int SEL_W = 5;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [4:0] SEL_RESET = 5'h00;
  localparam int LOCK_BIT = 0;

  // Register byte addresses
  localparam logic [11:0] LOCK_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] INSEL_BASE = 12'h100;
  localparam logic [11:0] OUTSEL_BASE = 12'h200;

  // Status register bit positions
  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_ONE_WAY_BIT = 1;
  localparam int ST_CLEAR_USED_BIT = 2;
  localparam int ST_SET_USED_BIT = 3;

  // Unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Pin index layout: port A 0..5, port B 4..7, port C 0..7
  localparam int PORT_A_FIRST = 0;
  localparam int PORT_B_FIRST = 6;
  localparam int PORT_C_FIRST = 10;
  localparam int NUM_PINS = 18;
  localparam int NUM_INPUTS = 16;

  // Input selector codes
  localparam logic [4:0] IN_A_LAST = 5'h05;
  localparam logic [4:0] IN_B_FIRST = 5'h0C;
  localparam logic [4:0] IN_B_LAST = 5'h0F;
  localparam logic [4:0] IN_C_FIRST = 5'h10;
  localparam logic [4:0] IN_C_LAST_SMALL = 5'h15;
  localparam logic [4:0] IN_C_LAST_LARGE = 5'h17;

  // Output source codes
  localparam logic [4:0] OUT_LATCH = 5'h00;
  localparam logic [4:0] OUT_LC1 = 5'h04;
  localparam logic [4:0] OUT_LC2 = 5'h05;
  localparam logic [4:0] OUT_LC3 = 5'h06;
  localparam logic [4:0] OUT_GEN_A = 5'h08;
  localparam logic [4:0] OUT_GEN_B = 5'h09;
  localparam logic [4:0] OUT_GEN_C = 5'h0A;
  localparam logic [4:0] OUT_GEN_D = 5'h0B;
  localparam logic [4:0] OUT_CAPTURE_COMPARE_ONE = 5'h0C;
  localparam logic [4:0] OUT_CAPTURE_COMPARE_TWO = 5'h0D;
  localparam logic [4:0] OUT_PWM3 = 5'h0E;
  localparam logic [4:0] OUT_PWM4 = 5'h0F;
  localparam logic [4:0] OUT_SCK_SCL = 5'h10;
  localparam logic [4:0] OUT_SDA = 5'h11;
  localparam logic [4:0] OUT_SDO = 5'h12;
  localparam logic [4:0] OUT_SERIAL_TX_OR_CLOCK = 5'h14;
  localparam logic [4:0] OUT_DT = 5'h15;
  localparam logic [4:0] OUT_CMP1 = 5'h16;
  localparam logic [4:0] OUT_CMP2 = 5'h17;

  // Peripheral output levels offered to every pin
  typedef struct packed {
    logic logic_cell_one_out;
    logic logic_cell_two_out;
    logic logic_cell_three_out;
    logic generator_out_a;
    logic generator_out_b;
    logic generator_out_c;
    logic generator_out_d;
    logic capture_compare_one;
    logic capture_compare_two;
    logic pulse_width_three_out;
    logic pulse_width_four_out;
    logic sck_scl;
    logic sda;
    logic sdo;
    logic serial_tx_or_clock;
    logic serial_sync_data;
    logic comparator_one_out;
    logic comparator_two_out;
  } periph_out_type;

  // One direction override request: take control, and drive when set
  typedef struct packed {
    logic take;
    logic drive;
  } dir_ovr_type;

  // Override requests of the sources that own their driver
  typedef struct packed {
    dir_ovr_type generator_a;
    dir_ovr_type generator_b;
    dir_ovr_type generator_c;
    dir_ovr_type generator_d;
    dir_ovr_type sck_scl;
    dir_ovr_type sda;
    dir_ovr_type serial_tx_or_clock;
    dir_ovr_type serial_sync_data;
  } periph_ovr_type;

endpackage : pin_route_pkg

// >>> rtl/pin_output_cell.sv
// One pin: output source selector, source mux and driver enable
`timescale 1ns/100ps
module pin_output_cell (
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // Selector write
  input wire logic wr_en,
  input wire logic [4:0] wr_data,
  output logic [4:0] sel,
  // Port side
  input wire logic port_output_latch,
  input wire logic port_direction_bit,
  // Peripheral side
  input wire pin_route_pkg::periph_out_type periph,
  input wire pin_route_pkg::periph_ovr_type ovr,
  // Pin driver
  output logic pin_out,
  output logic pin_oe_n
);

  logic data_next;
  logic oe_n_next;
  pin_route_pkg::dir_ovr_type req;

  // Selector clears only at power-on; warm resets never reach it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel <= pin_route_pkg::SEL_RESET; // [R19] [R12]
    end else if (wr_en) begin
      sel <= wr_data; // [R1]
    end
  end

  // Source mux; reserved codes drive low
  always_comb begin
    unique case (sel)
      pin_route_pkg::OUT_LATCH: data_next = port_output_latch; // [R2]
      pin_route_pkg::OUT_LC1: data_next = periph.logic_cell_one_out; // [R17]
      pin_route_pkg::OUT_LC2: data_next = periph.logic_cell_two_out;
      pin_route_pkg::OUT_LC3: data_next = periph.logic_cell_three_out;
      pin_route_pkg::OUT_GEN_A: data_next = periph.generator_out_a;
      pin_route_pkg::OUT_GEN_B: data_next = periph.generator_out_b;
      pin_route_pkg::OUT_GEN_C: data_next = periph.generator_out_c;
      pin_route_pkg::OUT_GEN_D: data_next = periph.generator_out_d;
      pin_route_pkg::OUT_CAPTURE_COMPARE_ONE: data_next = periph.capture_compare_one;
      pin_route_pkg::OUT_CAPTURE_COMPARE_TWO: data_next = periph.capture_compare_two;
      pin_route_pkg::OUT_PWM3: data_next = periph.pulse_width_three_out;
      pin_route_pkg::OUT_PWM4: data_next = periph.pulse_width_four_out;
      pin_route_pkg::OUT_SCK_SCL: data_next = periph.sck_scl; // [R18]
      pin_route_pkg::OUT_SDA: data_next = periph.sda;
      pin_route_pkg::OUT_SDO: data_next = periph.sdo;
      pin_route_pkg::OUT_SERIAL_TX_OR_CLOCK: data_next = periph.serial_tx_or_clock;
      pin_route_pkg::OUT_DT: data_next = periph.serial_sync_data;
      pin_route_pkg::OUT_CMP1: data_next = periph.comparator_one_out;
      pin_route_pkg::OUT_CMP2: data_next = periph.comparator_two_out;
      default: data_next = 1'b0; // [R18]
    endcase
  end

  // Only driver-owning sources may take the enable away from the direction bit
  always_comb begin
    unique case (sel)
      pin_route_pkg::OUT_GEN_A: req = ovr.generator_a; // [R4] [R5]
      pin_route_pkg::OUT_GEN_B: req = ovr.generator_b;
      pin_route_pkg::OUT_GEN_C: req = ovr.generator_c;
      pin_route_pkg::OUT_GEN_D: req = ovr.generator_d;
      pin_route_pkg::OUT_SCK_SCL: req = ovr.sck_scl;
      pin_route_pkg::OUT_SDA: req = ovr.sda;
      pin_route_pkg::OUT_SERIAL_TX_OR_CLOCK: req = ovr.serial_tx_or_clock;
      pin_route_pkg::OUT_DT: req = ovr.serial_sync_data;
      default: req = '0;
    endcase
    oe_n_next = req.take ? !req.drive : port_direction_bit; // [R3]
  end

  // Registered pin drive; driver off at power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out <= data_next;
      pin_oe_n <= oe_n_next;
    end
  end

endmodule : pin_output_cell

// >>> rtl/pin_route_matrix.sv
// Pin routing matrix: APB register file, lock logic, input and output routing
`timescale 1ns/100ps
module pin_route_matrix #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int NUM_PINS = pin_route_pkg::NUM_PINS,
  parameter int NUM_INPUTS = pin_route_pkg::NUM_INPUTS,
  parameter logic [NUM_INPUTS-1:0][4:0] INPUT_DEFAULTS = '0
) (
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // Non power-on device reset, synchronous, active high
  input wire logic warm_reset,
  // Configuration bit for one-way lock
  input wire logic one_way_lock_config,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port side
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] port_output_latch,
  input wire logic [NUM_PINS-1:0] port_direction_bit,
  output logic [NUM_PINS-1:0] port_read,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n,
  // Peripheral side
  input wire pin_route_pkg::periph_out_type periph_out,
  input wire pin_route_pkg::periph_ovr_type periph_ovr,
  output logic [NUM_INPUTS-1:0] periph_in,
  output logic route_locked_flag
);

  // Lock key tracker
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_HALF = 3'b010,
    KEY_ARMED = 3'b100
  } key_state_type;

  key_state_type key_reg;
  key_state_type key_next;
  logic pready_reg;
  logic access;
  logic commit;
  logic write_commit;
  logic aligned;
  logic hit_lock;
  logic hit_status;
  logic hit_in;
  logic hit_out;
  logic [11:0] in_offset;
  logic [11:0] out_offset;
  logic [9:0] in_index;
  logic [9:0] out_index;
  logic [31:0] rdata_next;
  logic clear_used_reg;
  logic set_used_reg;
  logic lock_write;
  logic lock_value;
  logic lock_allowed;
  logic sel_write_ok;
  logic [NUM_INPUTS-1:0][4:0] in_sel_reg;
  logic [NUM_PINS-1:0][4:0] out_sel;

  // Map an input code to a pin level; reserved codes read low
  function automatic logic route_pin(input logic [4:0] code, input logic [NUM_PINS-1:0] pins);
    logic level;
    level = 1'b0;
    if (code <= pin_route_pkg::IN_A_LAST) begin
      level = pins[pin_route_pkg::PORT_A_FIRST + int'(code)]; // [R15]
    end else if (LARGE_VARIANT && code >= pin_route_pkg::IN_B_FIRST && code <= pin_route_pkg::IN_B_LAST) begin
      level = pins[pin_route_pkg::PORT_B_FIRST + int'(code - pin_route_pkg::IN_B_FIRST)]; // [R16]
    end else if (code >= pin_route_pkg::IN_C_FIRST && code <= (LARGE_VARIANT ?
        pin_route_pkg::IN_C_LAST_LARGE : pin_route_pkg::IN_C_LAST_SMALL)) begin
      level = pins[pin_route_pkg::PORT_C_FIRST + int'(code - pin_route_pkg::IN_C_FIRST)]; // [R15] [R16]
    end
    return level;
  endfunction : route_pin

  // APB decode; every register sits in the low byte of an aligned word
  always_comb begin
    aligned = (paddr[1:0] == 2'b00);
    in_offset = paddr - pin_route_pkg::INSEL_BASE;
    out_offset = paddr - pin_route_pkg::OUTSEL_BASE;
    in_index = in_offset[11:2];
    out_index = out_offset[11:2];
    hit_lock = aligned && (paddr == pin_route_pkg::LOCK_OFFSET);
    hit_status = aligned && (paddr == pin_route_pkg::STATUS_OFFSET);
    hit_in = aligned && (paddr >= pin_route_pkg::INSEL_BASE) && (int'(in_index) < NUM_INPUTS);
    hit_out = aligned && (paddr >= pin_route_pkg::OUTSEL_BASE) && (int'(out_index) < NUM_PINS);
  end

  // One wait state: pready rises in the second access cycle
  assign access = psel && penable;
  assign commit = access && pready_reg;
  assign write_commit = commit && pwrite && pstrb[0];
  assign lock_write = write_commit && hit_lock;
  assign lock_value = pwdata[pin_route_pkg::LOCK_BIT];
  assign sel_write_ok = write_commit && !route_locked_flag; // [R7]

  // Read mux; unused upper bits read zero
  always_comb begin
    rdata_next = '0;
    if (hit_lock) begin
      rdata_next[pin_route_pkg::LOCK_BIT] = route_locked_flag; // [R22]
    end else if (hit_status) begin
      rdata_next[pin_route_pkg::ST_LOCKED_BIT] = route_locked_flag;
      rdata_next[pin_route_pkg::ST_ONE_WAY_BIT] = one_way_lock_config;
      rdata_next[pin_route_pkg::ST_CLEAR_USED_BIT] = clear_used_reg;
      rdata_next[pin_route_pkg::ST_SET_USED_BIT] = set_used_reg;
    end else if (hit_in) begin
      rdata_next[4:0] = in_sel_reg[in_index]; // [R14]
    end else if (hit_out) begin
      rdata_next[4:0] = out_sel[out_index]; // [R19]
    end
  end

  // Bus answer; unmapped addresses answer with pslverr and zero data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready_reg <= access && !pready_reg;
      if (access && !pready_reg) begin
        prdata <= pwrite ? '0 : rdata_next;
        pslverr <= !(hit_lock || hit_status || hit_in || hit_out);
      end else begin
        prdata <= '0;
        pslverr <= 1'b0;
      end
    end
  end

  assign pready = pready_reg;

  // Key sequence; any other write to byte 0 in between breaks it
  always_comb begin
    key_next = key_reg;
    if (write_commit) begin
      if (hit_lock && pwdata[7:0] == pin_route_pkg::KEY_FIRST && key_reg != KEY_ARMED) begin
        key_next = KEY_HALF; // [R8]
      end else if (hit_lock && pwdata[7:0] == pin_route_pkg::KEY_SECOND && key_reg == KEY_HALF) begin
        key_next = KEY_ARMED; // [R8]
      end else begin
        key_next = KEY_IDLE; // [R23]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_reg <= KEY_IDLE;
    end else if (warm_reset) begin
      key_reg <= KEY_IDLE;
    end else begin
      key_reg <= key_next;
    end
  end

  // One-way mode grants a single clear and a single set per reset
  always_comb begin
    if (!one_way_lock_config) begin
      lock_allowed = 1'b1;
    end else if (lock_value) begin
      lock_allowed = !set_used_reg; // [R9]
    end else begin
      lock_allowed = !clear_used_reg && !set_used_reg; // [R9] [R10]
    end
  end

  // Lock flag and one-way bookkeeping clear on every kind of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_locked_flag <= 1'b0;
      clear_used_reg <= 1'b0;
      set_used_reg <= 1'b0;
    end else if (warm_reset) begin
      route_locked_flag <= 1'b0;
      clear_used_reg <= 1'b0;
      set_used_reg <= 1'b0;
    end else if (lock_write && key_reg == KEY_ARMED && lock_allowed) begin
      route_locked_flag <= lock_value; // [R8] [R22]
      if (one_way_lock_config && lock_value) begin
        set_used_reg <= 1'b1; // [R10]
      end
      if (one_way_lock_config && !lock_value) begin
        clear_used_reg <= 1'b1; // [R9]
      end
    end
  end

  // Input selectors: power-on defaults only, warm reset and sleep leave them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sel_reg <= INPUT_DEFAULTS; // [R12]
    end else if (sel_write_ok && hit_in) begin
      in_sel_reg[in_index] <= pwdata[4:0]; // [R14] [R13] [R11]
    end
  end

  // Each peripheral input samples its chosen pin; pins may be shared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_in <= '0;
    end else begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        periph_in[i] <= route_pin(in_sel_reg[i], pin_in); // [R20]
      end
    end
  end

  // Port reads see the pin itself, never the routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_read <= '0;
    end else begin
      port_read <= pin_in; // [R21]
    end
  end

  // One output cell per pin
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    pin_output_cell u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(sel_write_ok && hit_out && int'(out_index) == p), // [R1] [R7]
      .wr_data(pwdata[4:0]),
      .sel(out_sel[p]),
      .port_output_latch(port_output_latch[p]),
      .port_direction_bit(port_direction_bit[p]),
      .periph(periph_out),
      .ovr(periph_ovr),
      .pin_out(pin_out[p]),
      .pin_oe_n(pin_oe_n[p])
    );
  end

endmodule : pin_route_matrix

// >>> tb/route_checker_assertions.sv
// Port checker of the pin routing matrix
`timescale 1ns/100ps
module route_checker #(
  parameter int NUM_PINS = 18
) (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic warm_reset,
  input wire logic one_way_lock_config,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and peripherals
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] port_direction_bit,
  input wire logic [NUM_PINS-1:0] port_read,
  input wire logic [NUM_PINS-1:0] pin_oe_n,
  input wire pin_route_pkg::periph_ovr_type periph_ovr,
  input wire logic route_locked_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Completed read, and no source asking for its driver
  logic rd_done;
  logic no_take;
  assign rd_done = psel && penable && pready && !pwrite;
  assign no_take = (periph_ovr & 16'hAAAA) == 16'h0000;

  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  property p_wait_state;
    psel && !penable |=> s_one_wait;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("answer not after one wait state");

  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error flag without ready");

  property p_lock_read;
    rd_done && paddr == pin_route_pkg::LOCK_OFFSET |-> prdata == {31'h0, route_locked_flag};
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read value wrong");

  property p_sel_read;
    rd_done && paddr[11:8] != 4'h0 |-> prdata[31:5] == 27'h0;
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("selector upper bits not zero");

  // Only a completed lock write may move the flag, warm reset aside
  property p_lock_change;
    $changed(route_locked_flag) && !$past(warm_reset)
      |-> $past(psel && penable && pready && pwrite && paddr == pin_route_pkg::LOCK_OFFSET);
  endproperty
  a_lock_change: assert property (p_lock_change) else $error("lock flag moved without lock write");

  property p_one_way_hold;
    route_locked_flag && one_way_lock_config && !warm_reset |=> route_locked_flag;
  endproperty
  a_one_way_hold: assert property (p_one_way_hold) else $error("one-way lock released");

  property p_dir_ctl;
    $past(presetn) && $past(no_take) |-> pin_oe_n == $past(port_direction_bit);
  endproperty
  a_dir_ctl: assert property (p_dir_ctl) else $error("driver enable not from direction bit");

  property p_port_read;
    $past(presetn) |-> port_read == $past(pin_in);
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read not the pin level");

  property p_por_default;
    $rose(presetn) |-> pin_oe_n == '1 && !route_locked_flag;
  endproperty
  a_por_default: assert property (p_por_default) else $error("power-on state wrong");
endmodule : route_checker

bind pin_route_matrix route_checker #(.NUM_PINS(NUM_PINS)) chk_u (
  .pclk(pclk), .presetn(presetn), .warm_reset(warm_reset), .one_way_lock_config(one_way_lock_config),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_in(pin_in), .port_direction_bit(port_direction_bit), .port_read(port_read),
  .pin_oe_n(pin_oe_n), .periph_ovr(periph_ovr), .route_locked_flag(route_locked_flag)
);

// >>> tb/periph_model.sv
// Far-side model: peripheral levels, override requests and pin wires
`timescale 1ns/100ps
module periph_model (
  // Clock
  input wire logic pclk,
  // Bench controls
  input wire logic [17:0] src_level,
  input wire logic [15:0] ovr_req,
  input wire logic [17:0] ext_level,
  // Pin wires
  input wire logic [17:0] pin_out,
  input wire logic [17:0] pin_oe_n,
  output logic [17:0] pin_in,
  // Peripheral side
  output pin_route_pkg::periph_out_type periph_out,
  output pin_route_pkg::periph_ovr_type periph_ovr
);
  // Peripherals change their outputs on the system clock only
  always_ff @(posedge pclk) begin
    periph_out <= pin_route_pkg::periph_out_type'(src_level);
    periph_ovr <= pin_route_pkg::periph_ovr_type'(ovr_req);
  end

  // Released pin shows the outside level, never the last driven one
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
endmodule : periph_model

// >>> tb/tb.sv
// Self-checking bench of the pin routing matrix
`timescale 1ns/100ps
module tb;
  localparam logic [15:0][4:0] IN_DEF = {75'h0, 5'h11};
  localparam logic [11:0] LOCK_A = pin_route_pkg::LOCK_OFFSET;
  // Output codes in the bit order of the peripheral level struct
  localparam logic [17:0][4:0] SRC_CODE = {5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
    5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h14, 5'h15, 5'h16, 5'h17};

  logic pclk, presetn, warm_reset, one_way_lock_config;
  logic psel, penable, pwrite, pready, pslverr, e, route_locked_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [17:0] pin_in, port_output_latch, port_direction_bit, port_read, pin_out, pin_oe_n, src_level, ext_level;
  logic [15:0] ovr_req, periph_in, periph_in_s;
  pin_route_pkg::periph_out_type periph_out;
  pin_route_pkg::periph_ovr_type periph_ovr;
  int mismatches, n_tests;

  pin_route_matrix #(.INPUT_DEFAULTS(IN_DEF)) dut_u (
    .pclk(pclk), .presetn(presetn), .warm_reset(warm_reset), .one_way_lock_config(one_way_lock_config),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .port_output_latch(port_output_latch),
    .port_direction_bit(port_direction_bit), .port_read(port_read), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .periph_out(periph_out), .periph_ovr(periph_ovr), .periph_in(periph_in), .route_locked_flag(route_locked_flag)
  );
  // Small variant shares the bus and pins; the bench compares only its input routing, the bound checker watches its ports too
  pin_route_matrix #(.LARGE_VARIANT(1'b0), .INPUT_DEFAULTS(IN_DEF)) small_u (
    .pclk(pclk), .presetn(presetn), .warm_reset(warm_reset), .one_way_lock_config(one_way_lock_config),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(), .pready(), .pslverr(), .pin_in(pin_in), .port_output_latch(port_output_latch),
    .port_direction_bit(port_direction_bit), .port_read(), .pin_out(), .pin_oe_n(),
    .periph_out(periph_out), .periph_ovr(periph_ovr), .periph_in(periph_in_s), .route_locked_flag()
  );
  periph_model far_u (
    .pclk(pclk), .src_level(src_level), .ovr_req(ovr_req), .ext_level(ext_level), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_in(pin_in), .periph_out(periph_out), .periph_ovr(periph_ovr)
  );

  // 100 ns clock
  always #50 pclk = ~pclk;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // One APB transfer; an idle edge follows so psel never toggles twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      mismatches++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk_reg(q, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  function automatic logic [11:0] osel(input int p);
    return pin_route_pkg::OUTSEL_BASE + 12'(4 * p);
  endfunction : osel

  function automatic logic [11:0] isel(input int i);
    return pin_route_pkg::INSEL_BASE + 12'(4 * i);
  endfunction : isel

  // Keys kept back to back, as software would with interrupts masked
  task automatic lock_write(input logic v);
    wr(LOCK_A, 32'h55);
    wr(LOCK_A, 32'hAA);
    wr(LOCK_A, {31'h0, v});
  endtask : lock_write

  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    warm_reset = 1'h0;
    one_way_lock_config = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    port_output_latch = 18'h0;
    port_direction_bit = 18'h0;
    src_level = 18'h0;
    ext_level = 18'h0;
    ovr_req = 16'h0;
    mismatches = 0;
    n_tests = 0;
    tick(10);
    presetn <= 1'h1;
    tick(1);
    rd(LOCK_A, 32'h0);
    rd(osel(5), 32'h0);
    rd(isel(0), 32'h11);
    apb(1'h0, 12'h0F0, 32'h0);
    chk_bit(e, 1'h1);
    // Every peripheral output source code on pin 0, high then low
    for (int i = 0; i < 18; i++) begin
      wr(osel(0), {27'h0, SRC_CODE[i]});
      src_level <= 18'h1 << i;
      tick(3);
      chk_bit(pin_out[0], 1'h1);
      chk_bit(pin_oe_n[0], 1'h0);
      src_level <= ~(18'h1 << i);
      tick(3);
      chk_bit(pin_out[0], 1'h0);
    end
    wr(osel(0), 32'hFF);
    rd(osel(0), 32'h1F);
    src_level <= 18'h3FFFF;
    tick(3);
    chk_bit(pin_out[0], 1'h0);
    wr(osel(0), 32'h0);
    port_output_latch <= 18'h1;
    tick(3);
    chk_bit(pin_out[0], 1'h1);
    // Generator takes the driver of an input pin
    wr(osel(1), 32'h08);
    port_direction_bit <= 18'h2;
    ovr_req <= 16'hC000;
    tick(3);
    chk_bit(pin_oe_n[1], 1'h0);
    ovr_req <= 16'h8000;
    tick(3);
    chk_bit(pin_oe_n[1], 1'h1);
    // Input routing with a shared pin and a reserved code
    port_direction_bit <= 18'h3FFFF;
    ovr_req <= 16'h0;
    wr(isel(2), 32'h12);
    wr(isel(3), 32'h12);
    wr(isel(4), 32'h0C);
    wr(isel(5), 32'h08);
    ext_level <= 18'h01040;
    tick(3);
    chk_reg({16'h0, periph_in}, 32'h001C);
    chk_reg({16'h0, periph_in_s}, 32'h000C);
    ext_level <= 18'h3EFBF;
    tick(3);
    chk_reg({16'h0, periph_in}, 32'hFFC3);
    chk_reg({14'h0, port_read}, 32'h3EFBF);
    // Bidirectional data on one pin, looped back through the pad
    wr(osel(13), 32'h15);
    wr(isel(6), 32'h13);
    ext_level <= 18'h0;
    src_level <= 18'h4;
    ovr_req <= 16'h0003;
    tick(4);
    chk_bit(periph_in[6], 1'h1);
    ovr_req <= 16'h0002;
    tick(4);
    chk_bit(periph_in[6], 1'h0);
    // Lock, refused writes and a broken key sequence
    lock_write(1'h1);
    chk_bit(route_locked_flag, 1'h1);
    wr(osel(2), 32'h04);
    rd(osel(2), 32'h0);
    wr(isel(2), 32'h00);
    rd(isel(2), 32'h12);
    wr(LOCK_A, 32'h0);
    rd(LOCK_A, 32'h1);
    wr(LOCK_A, 32'h55);
    wr(osel(2), 32'h0);
    wr(LOCK_A, 32'hAA);
    wr(LOCK_A, 32'h0);
    rd(LOCK_A, 32'h1);
    lock_write(1'h0);
    rd(LOCK_A, 32'h0);
    // Warm reset keeps selections, clears the lock
    wr(osel(3), 32'h16);
    lock_write(1'h1);
    warm_reset <= 1'h1;
    tick(1);
    warm_reset <= 1'h0;
    tick(1);
    rd(osel(3), 32'h16);
    rd(LOCK_A, 32'h0);
    // Power-on reset in mid-run, then one-way mode
    presetn <= 1'h0;
    one_way_lock_config <= 1'h1;
    tick(2);
    presetn <= 1'h1;
    tick(1);
    rd(osel(3), 32'h0);
    rd(isel(2), 32'h0);
    rd(isel(0), 32'h11);
    lock_write(1'h0);
    lock_write(1'h1);
    rd(LOCK_A, 32'h1);
    rd(pin_route_pkg::STATUS_OFFSET, 32'hF);
    lock_write(1'h0);
    rd(LOCK_A, 32'h1);
    wr(osel(4), 32'h05);
    rd(osel(4), 32'h0);
    wrap_up();
  end
endmodule : tb
